// File: hdl/rcqf_core.v
/*
  Rate-control long-term range selection, short-term QP adjustment,
  bit-save state and encoder flatness decision, with a classic Wishbone
  register slave. Assumes all group inputs come from logic on sys_clk and
  are valid in the cycle their strobe is high.
*/
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "rcqf_defs.vh"
module rcqf_core #(
  parameter QPW = 5,
  parameter FW  = 16
) (
  input  wire            sys_clk,
  input  wire            resetn,
  input  wire [7:0]      wb_adr_i,
  input  wire [31:0]     wb_dat_i,
  input  wire [3:0]      wb_sel_i,
  input  wire            wb_we_i,
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  output reg  [31:0]     wb_dat_o,
  output reg             wb_ack_o,
  input  wire            group_valid,
  input  wire [FW-1:0]   model_fill_level,
  input  wire [FW-1:0]   rate_buffer_level,
  input  wire [FW-1:0]   transform_offset,
  input  wire            first_line,
  input  wire            second_line,
  input  wire [2:0]      pixels_in_group,
  input  wire [FW-1:0]   rate_size_prior_group,
  input  wire [FW-1:0]   coded_size_prior_group,
  input  wire [31:0]     predicted_sizes,
  input  wire            history_coded_flag,
  input  wire [2:0]      midpoint_unit_count,
  input  wire            group_flat_signalled,
  input  wire            group_flat_very,
  input  wire            slice_start,
  input  wire            flat_check_valid,
  input  wire [63:0]     spread_check1,
  input  wire [63:0]     spread_check2,
  input  wire            flat_single_pixel,
  input  wire            flat_next_line,
  output reg  [QPW-1:0]  main_quant_param,
  output reg             qp_valid,
  output reg  [3:0]      range_index,
  output reg  [1:0]      bit_saving_state,
  output reg             flat_valid,
  output reg             flat_flag,
  output reg  [1:0]      flat_group,
  output reg             flat_very
);
  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function [QPW-1:0] flat_qp;
    input [QPW-1:0] qp;
    input           very;
    input [4:0]     bpc;
    begin
      if (very)
        flat_qp = 5'h01 + {bpc[3:0] - 4'h8, 1'b0};
      else if (qp > `RCQF_FLAT_QP_DROP)
        flat_qp = qp - `RCQF_FLAT_QP_DROP;
      else
        flat_qp = 5'h00;
    end
  endfunction

  function [3:0] qp_to_level;
    input [QPW-1:0] qp;
    input [4:0]     bpc;
    reg   [3:0]     lv;
    begin
      lv = 4'h0;
      case (qp)
        5'd0, 5'd1, 5'd2: lv = 4'h0;
        5'd3, 5'd4: lv = 4'h1;
        5'd5, 5'd6: lv = 4'h2;
        5'd7, 5'd8: lv = 4'h3;
        5'd9, 5'd10: lv = 4'h4;
        5'd11, 5'd12: lv = 4'h5;
        5'd13, 5'd14: lv = 4'h6;
        5'd15, 5'd16, 5'd17: lv = 4'h7;
        5'd18: lv = 4'h8;
        5'd19, 5'd20, 5'd21: lv = 4'h9;
        5'd22: lv = 4'hA;
        5'd23, 5'd24, 5'd25: lv = 4'hB;
        5'd26: lv = 4'hC;
        5'd27, 5'd28, 5'd29: lv = 4'hD;
        5'd30: lv = 4'hE;
        default: lv = 4'hF;
      endcase
      if ((bpc == 5'd8 && qp == 5'd13) || (bpc == 5'd10 && qp == 5'd17) ||
          (bpc == 5'd12 && qp == 5'd21) || (bpc == 5'd14 && qp == 5'd25))
        lv = lv - 4'h1;
      qp_to_level = lv;
    end
  endfunction

  // Grade one group from four component spreads: 2 very, 1 somewhat, 0 none
  function [1:0] grade;
    input [63:0] sp;
    input [15:0] very_lim;
    input [15:0] mild_lim;
    integer      c;
    reg          v;
    reg          m;
    begin
      v = 1'b1;
      m = 1'b1;
      for (c = 0; c < 4; c = c + 1) begin
        if (sp[c*16 +: 16] > very_lim) v = 1'b0;
        if (sp[c*16 +: 16] > mild_lim) m = 1'b0;
      end
      grade = v ? 2'h2 : (m ? 2'h1 : 2'h0);
    end
  endfunction

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  reg  [31:0]    ctrl_q, depth_q, bpp_q, margin_q, lineofs_q;
  reg  [31:0]    nfl_q, nsl_q, slice_q, flatqp_q, cap_q;
  reg  [15:0]    thr_q [0:13];
  reg  [21:0]    rng_q [0:14];
  reg  [1:0]     mpp_state_q;
  reg  [QPW-1:0] last_qp_q, second_last_qp_q;
  reg  [31:0]    rd_val;
  wire [31:0]    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0]    wval  = (rd_val & ~wmask) | (wb_dat_i & wmask);
  wire           wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire [3:0]     thr_i = wb_adr_i[5:2];
  wire [3:0]     rng_i = wb_adr_i[5:2];
  wire           thr_hit = (wb_adr_i[7:6] == 2'b01) && (thr_i < 4'd14);
  wire           rng_hit = (wb_adr_i[7:6] == 2'b10) && (rng_i < 4'd15);
  integer        k;
  integer        j;

  always @* begin
    rd_val = 32'h0000_0000;
    case (wb_adr_i)
      `RCQF_OFS_CTRL:    rd_val = ctrl_q;
      `RCQF_OFS_DEPTH:   rd_val = depth_q;
      `RCQF_OFS_BPP:     rd_val = bpp_q;
      `RCQF_OFS_MARGIN:  rd_val = margin_q;
      `RCQF_OFS_LINEOFS: rd_val = lineofs_q;
      `RCQF_OFS_NFL:     rd_val = nfl_q;
      `RCQF_OFS_NSL:     rd_val = nsl_q;
      `RCQF_OFS_SLICE:   rd_val = slice_q;
      `RCQF_OFS_FLATQP:  rd_val = flatqp_q;
      `RCQF_OFS_CAP:     rd_val = cap_q;
      `RCQF_OFS_STATUS:  rd_val = {14'h0000, mpp_state_q, bit_saving_state,
                                   range_index, 5'h00, main_quant_param};
      default: begin
        if (thr_hit) rd_val = {16'h0000, thr_q[thr_i]};
        else if (rng_hit) rd_val = {10'h000, rng_q[rng_i]};
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      ctrl_q    <= `RCQF_RST_CTRL;
      depth_q   <= `RCQF_RST_DEPTH;
      bpp_q     <= `RCQF_RST_BPP;
      margin_q  <= `RCQF_RST_MARGIN;
      lineofs_q <= 32'h0000_0000;
      nfl_q     <= 32'h0000_0000;
      nsl_q     <= 32'h0000_0000;
      slice_q   <= 32'h0000_0000;
      flatqp_q  <= `RCQF_RST_FLATQP;
      cap_q     <= `RCQF_RST_CAP;
      for (k = 0; k < 14; k = k + 1) thr_q[k] <= 16'h0000;
      for (k = 0; k < 15; k = k + 1) rng_q[k] <= 22'h00_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_val;
      if (wr_en) begin
        case (wb_adr_i)
          `RCQF_OFS_CTRL:    ctrl_q    <= {28'h000_0000, wval[3:0]};
          `RCQF_OFS_DEPTH:   depth_q   <= {19'h0_0000, wval[12:8], 3'h0, wval[4:0]};
          `RCQF_OFS_BPP:     bpp_q     <= {22'h00_0000, wval[9:0]};
          `RCQF_OFS_MARGIN:  margin_q  <= {16'h0000, wval[15:0]};
          `RCQF_OFS_LINEOFS: lineofs_q <= {16'h0000, wval[15:0]};
          `RCQF_OFS_NFL:     nfl_q     <= {16'h0000, wval[15:0]};
          `RCQF_OFS_NSL:     nsl_q     <= {16'h0000, wval[15:0]};
          `RCQF_OFS_SLICE:   slice_q   <= {16'h0000, wval[15:0]};
          `RCQF_OFS_FLATQP:  flatqp_q  <= {19'h0_0000, wval[12:8], 3'h0, wval[4:0]};
          `RCQF_OFS_CAP:     cap_q     <= {16'h0000, wval[15:0]};
          default: begin
            if (thr_hit)
              thr_q[thr_i] <= {wval[15:`RCQF_THR_LSB], 6'h00};
            else if (rng_hit)
              rng_q[rng_i] <= wval[21:0];
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Long-term range selection
  // --------------------------------------------------------------------
  wire [1:0]     minor = ctrl_q[1:0];
  wire           v2    = (minor == `RCQF_MINOR_V2);
  wire           n422  = ctrl_q[`RCQF_CTRL_N422];
  wire [4:0]     bpc0  = depth_q[4:0];
  wire [4:0]     bpc1  = depth_q[12:8];
  reg  [3:0]     range_d;
  always @* begin
    range_d = 4'd14;
    for (j = 13; j >= 0; j = j - 1)
      if ($signed(model_fill_level) < $signed(thr_q[j])) range_d = j[3:0];
    if ($signed(model_fill_level) > 0) range_d = 4'd14;
  end
  wire [QPW-1:0] working_qp_floor   = rng_q[range_d][4:0];
  wire [QPW-1:0] working_qp_ceiling = rng_q[range_d][12:8];
  wire [15:0]    working_bits_adjust = {{10{rng_q[range_d][21]}}, rng_q[range_d][21:16]};
  wire [QPW-1:0] top_ceiling = rng_q[14][12:8];

  // --------------------------------------------------------------------
  // Bit-save state
  // --------------------------------------------------------------------
  wire [7:0]  ps0 = predicted_sizes[7:0];
  wire [7:0]  ps1 = predicted_sizes[15:8];
  wire [7:0]  ps2 = predicted_sizes[23:16];
  wire [7:0]  ps3 = predicted_sizes[31:24];
  wire [9:0]  ps_sum = {2'b00, ps0} + {2'b00, ps1} + {2'b00, ps2} + {2'b00, ps3};
  wire [9:0]  predicted_activity = n422 ? ({5'h00, last_qp_q} + {1'b0, ps_sum[9:1]})
                                 : ({5'h00, last_qp_q} + {2'b00, ps0}
                                   + {2'b00, (ps1 > ps2) ? ps1 : ps2});
  wire [5:0]  bit_saving_threshold = {1'b0, bpc0} + {1'b0, bpc1} - 6'd2;
  reg  [1:0]  save_d, mpp_d;
  always @* begin
    save_d = 2'h0;
    mpp_d  = 2'h0;
    if (v2 && !first_line && !group_flat_signalled) begin
      if (history_coded_flag && midpoint_unit_count >= `RCQF_MP_UNITS_MIN) begin
        mpp_d  = (mpp_state_q == `RCQF_SAVE_TOP) ? `RCQF_SAVE_TOP : mpp_state_q + 2'h1;
        save_d = (mpp_d == `RCQF_SAVE_TOP) ? `RCQF_SAVE_TOP : bit_saving_state;
      end else if (history_coded_flag &&
                   predicted_activity >= {4'h0, bit_saving_threshold}) begin
        mpp_d  = mpp_state_q;
        save_d = bit_saving_state;
      end else if (history_coded_flag) begin
        mpp_d  = mpp_state_q;
        save_d = (bit_saving_state == 2'h0) ? 2'h1 : bit_saving_state;
      end
    end
  end

  // --------------------------------------------------------------------
  // Target bits and short-term QP
  // --------------------------------------------------------------------
  reg  signed [15:0] line_bits_adjust;
  always @* begin
    if (first_line)
      line_bits_adjust = {{8{lineofs_q[7]}}, lineofs_q[7:0]};
    else
      line_bits_adjust = -($signed(nfl_q[15:0]) >>> `RCQF_LINE_FRAC);
    if (second_line)
      line_bits_adjust = {{8{lineofs_q[15]}}, lineofs_q[15:8]};
    else
      line_bits_adjust = -($signed(nsl_q[15:0]) >>> `RCQF_LINE_FRAC);
    line_bits_adjust = line_bits_adjust - ($signed(slice_q[15:0]) >>> `RCQF_LINE_FRAC);
  end
  wire [12:0] pix_bits = {10'h000, pixels_in_group} * bpp_q[9:0];
  wire signed [15:0] group_bit_target = $signed({6'h00, pix_bits[12:3] + 10'h001} >> 1)
                     + $signed(working_bits_adjust) + line_bits_adjust;
  wire signed [15:0] tgt_low  = group_bit_target - $signed({8'h00, margin_q[7:0]});
  wire signed [15:0] tgt_high = group_bit_target + $signed({8'h00, margin_q[15:8]});
  wire signed [15:0] qp_step_amount =
       ($signed(coded_size_prior_group) - group_bit_target) >>> 1;
  wire signed [15:0] fill_sum = $signed(rate_buffer_level) + $signed(transform_offset);
  wire overflow_near = fill_sum > (n422 ? `RCQF_OVF_LIMIT_422 : `RCQF_OVF_LIMIT);

  wire [QPW-1:0] second_adj = (v2 && group_flat_signalled) ?
                 flat_qp(second_last_qp_q, group_flat_very, bpc0) : second_last_qp_q;
  wire [QPW-1:0] raised_qp_ceiling = working_qp_ceiling + 5'h01;
  wire [QPW-1:0] lowered_qp_floor  = (working_qp_ceiling > 5'h04) ?
                                     working_qp_ceiling - 5'h04 : 5'h00;
  wire [QPW-1:0] lim_hi = (v2 && bit_saving_state != 2'h0) ? raised_qp_ceiling
                                                            : working_qp_ceiling;
  wire [QPW-1:0] lim_lo = (v2 && bit_saving_state == `RCQF_SAVE_TOP) ? lowered_qp_floor
                                                                      : working_qp_floor;
  reg  [6:0]     qp_wide;
  reg  [QPW-1:0] short_term_quant_param;
  reg  [QPW-1:0] main_d;
  always @* begin
    qp_wide = {2'b00, last_qp_q};
    if ($signed(rate_size_prior_group) < `RCQF_MIN_GROUP_BITS ||
        ($signed(coded_size_prior_group) < tgt_low &&
         $signed(rate_size_prior_group) < tgt_low)) begin
      if (qp_wide > {2'b00, lim_lo}) qp_wide = qp_wide - 7'd1;
    end else if ($signed(coded_size_prior_group) > tgt_high ||
                 $signed(rate_size_prior_group) > tgt_high) begin
      if (second_adj < last_qp_q || qp_step_amount < 16'sd1)
        qp_wide = qp_wide + 7'd1;
      else
        qp_wide = qp_wide + ((qp_step_amount > 16'sd31) ? 7'd31 : qp_step_amount[6:0]);
    end
    if (qp_wide > {2'b00, lim_hi}) qp_wide = {2'b00, lim_hi};
    if (qp_wide < {2'b00, lim_lo}) qp_wide = {2'b00, lim_lo};
    short_term_quant_param = qp_wide[QPW-1:0];
    if (v2 && short_term_quant_param > working_qp_ceiling)
      short_term_quant_param = working_qp_ceiling;
    if (v2 && short_term_quant_param < working_qp_floor)
      short_term_quant_param = working_qp_floor;
    if (overflow_near) short_term_quant_param = top_ceiling;
    if (group_flat_signalled && last_qp_q != top_ceiling)
      main_d = flat_qp(short_term_quant_param, group_flat_very, bpc0);
    else
      main_d = short_term_quant_param;
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      main_quant_param <= 5'h00;
      last_qp_q        <= 5'h00;
      second_last_qp_q <= 5'h00;
      qp_valid         <= 1'b0;
      range_index      <= 4'h0;
      bit_saving_state <= 2'h0;
      mpp_state_q      <= 2'h0;
    end else begin
      qp_valid <= group_valid;
      if (group_valid) begin
        main_quant_param <= main_d;
        last_qp_q        <= main_d;
        second_last_qp_q <= last_qp_q;
        range_index      <= range_d;
        bit_saving_state <= save_d;
        mpp_state_q      <= mpp_d;
      end
    end
  end

  // --------------------------------------------------------------------
  // Encoder flatness decision
  // --------------------------------------------------------------------
  reg  [1:0]     sg_pos_q;
  reg            prev_flat_q;
  reg            sel_q;
  reg  [1:0]     sel_grp_q;
  reg            sel_very_q;
  reg  [QPW-1:0] sg_qp_q;
  wire [QPW-1:0] lvl_qp = (sg_qp_q > `RCQF_FLAT_QP_DROP) ? sg_qp_q - `RCQF_FLAT_QP_DROP : 5'h00;
  wire [3:0]     flat_quant_level = qp_to_level(lvl_qp, bpc0);
  wire [15:0]    very_flat_limit = 16'h0002 << (bpc0[3:0] - 4'h8);
  wire [15:0]    mild_limit = 16'h0001 << flat_quant_level;
  wire [1:0]     g1 = grade(spread_check1, very_flat_limit, mild_limit);
  wire [1:0]     g2 = grade(spread_check2, very_flat_limit, mild_limit);
  wire [1:0]     g_fin = flat_next_line ? 2'h0 :
                 ((g1 != 2'h0 || flat_single_pixel) ? g1 : g2);
  wire           cur_flat = (g_fin != 2'h0);
  wire           pick = !sel_q && !prev_flat_q && cur_flat;
  wire           in_range = (main_quant_param >= flatqp_q[4:0]) &&
                            (main_quant_param <= flatqp_q[12:8]);

  always @(posedge sys_clk) begin
    if (!resetn) begin
      sg_pos_q    <= 2'h0;
      prev_flat_q <= 1'b0;
      sel_q       <= 1'b0;
      sel_grp_q   <= 2'h0;
      sel_very_q  <= 1'b0;
      sg_qp_q     <= 5'h00;
      flat_valid  <= 1'b0;
      flat_flag   <= 1'b0;
      flat_group  <= 2'h0;
      flat_very   <= 1'b0;
    end else begin
      flat_valid <= 1'b0;
      if (slice_start) begin
        sg_pos_q    <= 2'h0;
        prev_flat_q <= 1'b0;
        sel_q       <= 1'b0;
      end else if (flat_check_valid) begin
        if (sg_pos_q == 2'h0) sg_qp_q <= second_last_qp_q;
        sg_pos_q    <= sg_pos_q + 2'h1;
        prev_flat_q <= cur_flat;
        if (pick) begin
          sel_q      <= 1'b1;
          sel_grp_q  <= sg_pos_q;
          sel_very_q <= (g_fin == 2'h2);
        end
        if (sg_pos_q == 2'h3) begin
          flat_valid  <= 1'b1;
          flat_flag   <= (sel_q | pick) & in_range;
          flat_group  <= pick ? sg_pos_q : sel_grp_q;
          flat_very   <= pick ? (g_fin == 2'h2) : sel_very_q;
          sel_q       <= 1'b0;
          prev_flat_q <= (sel_q | pick) & in_range;
        end
      end
    end
  end
endmodule // rcqf_core

// File: hdl/rcqf_defs.vh
/*
  Constants for the rate-control QP and flatness block: register byte
  offsets, field positions, reset values and fixed algorithm figures.
  Assumes inclusion by rcqf_core.v and by the test bench.
*/
`ifndef RCQF_DEFS_VH
`define RCQF_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RCQF_OFS_CTRL      8'h00
`define RCQF_OFS_DEPTH     8'h04
`define RCQF_OFS_BPP       8'h08
`define RCQF_OFS_MARGIN    8'h0C
`define RCQF_OFS_LINEOFS   8'h10
`define RCQF_OFS_NFL       8'h14
`define RCQF_OFS_NSL       8'h18
`define RCQF_OFS_SLICE     8'h1C
`define RCQF_OFS_FLATQP    8'h20
`define RCQF_OFS_CAP       8'h24
`define RCQF_OFS_STATUS    8'h28
`define RCQF_OFS_THR_BASE  8'h40
`define RCQF_OFS_RNG_BASE  8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCQF_CTRL_N422     2
`define RCQF_CTRL_N420     3
`define RCQF_THR_LSB       6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCQF_RST_CTRL      32'h0000_0002
`define RCQF_RST_DEPTH     32'h0000_0808
`define RCQF_RST_BPP       32'h0000_0080
`define RCQF_RST_MARGIN    32'h0000_0303
`define RCQF_RST_FLATQP    32'h0000_0C03
`define RCQF_RST_CAP       32'h0000_2000

// ----------------------------------------------------------------------
// Algorithm figures
// ----------------------------------------------------------------------
`define RCQF_MINOR_V1      2'h1
`define RCQF_MINOR_V2      2'h2
`define RCQF_MIN_GROUP_BITS 16'sh0003
`define RCQF_OVF_LIMIT     16'shFF54
`define RCQF_OVF_LIMIT_422 16'shFF20
`define RCQF_FLAT_QP_DROP  5'h04
`define RCQF_MP_UNITS_MIN  3'h3
`define RCQF_SAVE_TOP      2'h2
`define RCQF_BPP_FRAC      4
`define RCQF_LINE_FRAC     11

`endif

// File: verification/rcqf_core_chk.sv
/* Port checker for rcqf_core: bus handshake, group and flatness strobes.
   Assumes it is bound to rcqf_core by the statement at the foot. */
`timescale 1ns/1ns
module rcqf_chk #(
  parameter QPW = 5
) (
  input wire           sys_clk,
  input wire           resetn,
  input wire           wb_cyc_i,
  input wire           wb_stb_i,
  input wire           wb_ack_o,
  input wire           group_valid,
  input wire           qp_valid,
  input wire [QPW-1:0] main_quant_param,
  input wire [3:0]     range_index,
  input wire [1:0]     bit_saving_state,
  input wire           flat_check_valid,
  input wire           flat_valid,
  input wire           flat_flag,
  input wire [1:0]     flat_group,
  input wire           flat_very
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_qp_answer: assert property (group_valid |=> qp_valid) else $error("no qp");
  a_qp_cause: assert property (!group_valid |=> !qp_valid) else $error("stray qp");
  a_qp_hold: assert property (!group_valid |=> $stable(main_quant_param) &&
    $stable(range_index) && $stable(bit_saving_state)) else $error("qp moved");
  a_range_limit: assert property (qp_valid |-> range_index <= 4'hE)
    else $error("range out of set");
  a_save_limit: assert property (qp_valid |-> bit_saving_state != 2'h3)
    else $error("bit saving above two");
  a_flat_after: assert property (flat_valid |-> $past(flat_check_valid))
    else $error("flat result without check");
  a_flat_pulse: assert property (flat_valid |=> !flat_valid) else $error("flat held");
  a_flat_hold: assert property (!flat_valid |-> $stable({flat_flag, flat_group,
    flat_very})) else $error("flat result moved");
endmodule // rcqf_chk

bind rcqf_core rcqf_chk #(.QPW(QPW)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .group_valid(group_valid), .qp_valid(qp_valid), .main_quant_param(main_quant_param),
  .range_index(range_index), .bit_saving_state(bit_saving_state),
  .flat_check_valid(flat_check_valid), .flat_valid(flat_valid), .flat_flag(flat_flag),
  .flat_group(flat_group), .flat_very(flat_very));

// File: verification/rcqf_ent_model.sv
/* Entropy-side partner: issues group and flatness strobes with the flatness data.
   Assumes the bench raises requests one cycle ahead on sys_clk. */
`timescale 1ns/1ns
module rcqf_ent_model (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        grp_req,
  input  wire        flat_req,
  input  wire [63:0] c1_i,
  input  wire [63:0] c2_i,
  input  wire        sp_i,
  input  wire        nl_i,
  output reg         group_valid,
  output reg         flat_check_valid,
  output reg  [63:0] spread_check1,
  output reg  [63:0] spread_check2,
  output reg         flat_single_pixel,
  output reg         flat_next_line
);
  // Idle spreads are inverted, so stale data is not passed on unchanged
  always @(posedge sys_clk) begin
    group_valid       <= resetn & grp_req;
    flat_check_valid  <= resetn & flat_req;
    spread_check1     <= flat_req ? c1_i : ~c1_i;
    spread_check2     <= flat_req ? c2_i : ~c2_i;
    flat_single_pixel <= sp_i;
    flat_next_line    <= nl_i;
  end
endmodule // rcqf_ent_model

// File: verification/test_rate_control_qp_and_flatness.sv
/* Bench for rcqf_core: registers, range choice, bit-save state, flatness.
   Assumes rcqf_defs.vh on the include path and the partner model. */
`timescale 1ns/1ns
`include "rcqf_defs.vh"
module test_rate_control_qp_and_flatness;
  reg         sys_clk = 0, resetn = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  reg  [7:0]  wb_adr_i = 0;
  reg  [31:0] wb_dat_i = 0, q = 0, psz = 0;
  reg  [15:0] fill = 0, buf_lvl = 0, t_ofs = 0, rs = 16'h0010, cs = 16'h0010;
  reg         grp_req = 0, flat_req = 0, slice_start = 0, f_sp = 0, f_nl = 0, fl = 0;
  reg         hcf = 0, gfs = 0;
  reg  [63:0] f_c1 = 0, f_c2 = 0;
  reg  [2:0]  pix = 3'h3, mpc = 3'h0;
  wire [31:0] wb_dat_o;
  wire [63:0] sc1, sc2;
  wire [4:0]  qp;
  wire [3:0]  rng;
  wire [1:0]  bsv, fgrp;
  wire        wb_ack_o, gv, fcv, fsp, fnl, qpv, fv, fflag, fvery;
  integer     miscompares = 0, num_checks = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  rcqf_ent_model u_ent (.sys_clk(sys_clk), .resetn(resetn), .grp_req(grp_req),
    .flat_req(flat_req), .c1_i(f_c1), .c2_i(f_c2), .sp_i(f_sp), .nl_i(f_nl),
    .group_valid(gv), .flat_check_valid(fcv), .spread_check1(sc1), .spread_check2(sc2),
    .flat_single_pixel(fsp), .flat_next_line(fnl));
  rcqf_core dut (.sys_clk(sys_clk), .resetn(resetn), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .group_valid(gv),
    .model_fill_level(fill), .rate_buffer_level(buf_lvl), .transform_offset(t_ofs),
    .first_line(fl), .second_line(fl), .pixels_in_group(pix), .rate_size_prior_group(rs),
    .coded_size_prior_group(cs), .predicted_sizes(psz), .history_coded_flag(hcf),
    .midpoint_unit_count(mpc), .group_flat_signalled(gfs), .group_flat_very(gfs),
    .slice_start(slice_start), .flat_check_valid(fcv), .spread_check1(sc1),
    .spread_check2(sc2), .flat_single_pixel(fsp), .flat_next_line(fnl),
    .main_quant_param(qp), .qp_valid(qpv), .range_index(rng), .bit_saving_state(bsv),
    .flat_valid(fv), .flat_flag(fflag), .flat_group(fgrp), .flat_very(fvery));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      q = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    begin
      wb(0, a, 0);
      chk($sformatf("register %h", a), e, q);
    end
  endtask
  task grp(input [15:0] f, input [15:0] b);
    begin
      @(posedge sys_clk);
      fill <= f;
      buf_lvl <= b;
      grp_req <= 1;
      @(posedge sys_clk);
      grp_req <= 0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task fc(input f1, input f2, input sp, input nl);
    begin
      @(posedge sys_clk);
      f_c1 <= f1 ? 64'h0 : {4{16'hFFFF}};
      f_c2 <= f2 ? 64'h0 : {4{16'hFFFF}};
      f_sp <= sp;
      f_nl <= nl;
      flat_req <= 1;
    end
  endtask
  task fend(input ef, input [1:0] eg);
    begin
      @(posedge sys_clk);
      flat_req <= 0;
      repeat (3) @(posedge sys_clk);
      chk("flat flag", {31'h0, ef}, {31'h0, fflag});
      if (ef) chk("flat group", {30'h0, eg}, {30'h0, fgrp});
      if (ef) chk("flat very", 1, {31'h0, fvery});
    end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    begin
      rchk(`RCQF_OFS_CTRL, `RCQF_RST_CTRL);
      rchk(`RCQF_OFS_DEPTH, `RCQF_RST_DEPTH);
      rchk(`RCQF_OFS_BPP, `RCQF_RST_BPP);
      rchk(`RCQF_OFS_MARGIN, `RCQF_RST_MARGIN);
      rchk(`RCQF_OFS_FLATQP, `RCQF_RST_FLATQP);
      rchk(`RCQF_OFS_CAP, `RCQF_RST_CAP);
      wb(1, `RCQF_OFS_THR_BASE, 32'h0000_FFFF);
      rchk(`RCQF_OFS_THR_BASE, 32'h0000_FFC0);
      wb(1, 8'h3C, 32'hFFFF_FFFF);
      rchk(8'h3C, 32'h0000_0000);
    end
  endtask
  task t_range;
    begin
      wb(1, `RCQF_OFS_THR_BASE, 32'h0000_F000);
      wb(1, `RCQF_OFS_RNG_BASE, 32'h0000_0505);
      wb(1, 8'hB8, 32'h0000_1414);
      grp(16'hE000, 16'hF000);
      chk("range", 0, {28'h0, rng});
      chk("qp", 5, {27'h0, qp});
      chk("bit saving", 0, {30'h0, bsv});
      grp(16'h0001, 16'h0000);
      chk("range", 14, {28'h0, rng});
      chk("qp", 20, {27'h0, qp});
      rchk(`RCQF_OFS_STATUS, 32'h0000_3814);
    end
  endtask
  task t_save;
    begin
      hcf <= 1;
      mpc <= 3'h3;
      grp(16'hE000, 16'hF000);
      chk("bit saving", 0, {30'h0, bsv});
      grp(16'hE000, 16'hF000);
      chk("bit saving", 2, {30'h0, bsv});
      mpc <= 3'h0;
      grp(16'hE000, 16'hF000);
      chk("bit saving", 2, {30'h0, bsv});
      chk("qp", 5, {27'h0, qp});
      hcf <= 0;
      gfs <= 1;
      grp(16'hE000, 16'hF000);
      chk("bit saving", 0, {30'h0, bsv});
      chk("qp", 1, {27'h0, qp});
      gfs <= 0;
    end
  endtask
  task t_flat;
    begin
      @(posedge sys_clk);
      slice_start <= 1;
      @(posedge sys_clk);
      slice_start <= 0;
      fc(1, 0, 0, 0); fc(0, 0, 0, 0); fc(0, 0, 0, 0); fc(0, 0, 0, 0);
      fend(0, 0);
      grp(16'hE000, 16'hF000);
      fc(1, 0, 0, 0); fc(0, 0, 0, 0); fc(0, 0, 0, 0); fc(0, 0, 0, 0);
      fend(1, 0);
      fc(0, 0, 0, 0); fc(0, 0, 0, 0); fc(0, 1, 0, 0); fc(0, 0, 0, 0);
      fend(1, 2);
      fc(0, 0, 0, 0); fc(1, 0, 0, 1); fc(0, 1, 1, 0); fc(0, 0, 0, 0);
      fend(0, 0);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1;
    t_regs;
    t_range;
    t_flat;
    t_save;
    print_verdict;
  end
endmodule // test_rate_control_qp_and_flatness
